// file: pkg/clksw_defines.vh
`ifndef CLKSW_DEFINES_VH
`define CLKSW_DEFINES_VH

// ***************************************************************
// register byte addresses
// ***************************************************************
`define CLKSW_ADDR_OSC_CTRL   8'h00
`define CLKSW_ADDR_TUNING     8'h04
`define CLKSW_ADDR_SEC_TIMER  8'h08
`define CLKSW_ADDR_STATUS     8'h0C

// ***************************************************************
// oscillator_control fields
// ***************************************************************
`define CLKSW_IDLE_BIT        7
`define CLKSW_FREQ_HI         6
`define CLKSW_FREQ_LO         4
`define CLKSW_PSTART_BIT      3
`define CLKSW_IFSTAB_BIT      2
`define CLKSW_SEL_HI          1
`define CLKSW_SEL_LO          0

// ***************************************************************
// oscillator_tuning and secondary_timer_control fields
// ***************************************************************
`define CLKSW_LFSRC_BIT       7
`define CLKSW_MULEN_BIT       6
`define CLKSW_TUNE_HI         4
`define CLKSW_SECACT_BIT      6
`define CLKSW_SECEN_BIT       3

// ***************************************************************
// codes and reset values
// ***************************************************************
`define CLKSW_SEL_PRI         2'h0
`define CLKSW_SEL_SEC         2'h1
`define CLKSW_FREQ_RST        3'h4
`define CLKSW_FREQ_8M         3'h7
`define CLKSW_FREQ_4M         3'h6
`define CLKSW_FREQ_31K        3'h0
`define CLKSW_PCFG_INT_A      4'h8
`define CLKSW_PCFG_INT_B      4'h9
`define CLKSW_OLD_CYCLES      2'h2
`define CLKSW_NEW_CYCLES      2'h3

`endif

// file: hw/clksw_postscaler.v
`timescale 1ns/10ps
`default_nettype none

// divides the fast internal source; stage n is divide by 2^(n+1)
module clksw_postscaler
(
  // clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // fast source tick
  input  wire       fast_tick,
  // taps
  output wire [7:0] div_tick
);

  reg [7:0] cnt_r;
  wire [7:0] cnt_nxt;

  assign cnt_nxt = fast_tick ? cnt_r + 8'h01 : cnt_r;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_r <= 8'h00;
    else
      cnt_r <= cnt_nxt;
  end

  // one tick per wrap of each stage
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_tap
      assign div_tick[i] = fast_tick & (&cnt_r[i:0]);
    end
  endgenerate

endmodule // clksw_postscaler

`default_nettype wire

// file: hw/clksw_edge_count.v
`timescale 1ns/10ps
`default_nettype none

// counts ticks of one source during a switch
module clksw_edge_count
(
  // clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // control
  input  wire       clear,
  input  wire       tick,
  // count
  output wire [2:0] count
);

  reg [2:0] count_r;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count_r <= 3'h0;
    else if (clear)
      count_r <= 3'h0;
    else if (tick && count_r != 3'h7)
      count_r <= count_r + 3'h1;
  end

  assign count = count_r;

endmodule // clksw_edge_count

`default_nettype wire

// file: hw/clksw_top.v
// Notes on behaviour
// - select 00 primary, 01 secondary, 1x internal block.
// - every reset clears the source select field.
// - writing a new select starts the switch at once.
// - clock pauses two old cycles plus three new cycles, glitch free.
// - frequency field codes 111 down to 000 pick 8 MHz to 31 kHz.
// - frequency field resets to the 1 MHz code.
// - while internal drives, frequency changes take effect immediately.
// - code 000: low_freq_source_select picks fast/256 or slow RC.
// - slow RC always clocks the watchdog.
// - primary_startup_done reads 1 after start-up timer expiry while primary drives the clock.
// - internal_freq_stable set when fast source stable and driving.
// - secondary_clock_active set while secondary drives the clock.
// - at most one of three source status bits set.
// - sleep request enters idle if idle_on_sleep, else sleep.
// - secondary selection ignored while secondary oscillator disabled.
// - primary_startup_done reset value follows two-speed start-up config.
// - primary oscillator mode set by configuration inputs only.
// - multiplier works only in internal primary mode at 8/4 MHz.
//
// Decided for this implementation: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "clksw_defines.vh"

module clksw_top
(
  // ahb-lite
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // source ticks, one hclk wide
  input  wire        pri_tick,
  input  wire        sec_tick,
  input  wire        fast_tick,
  input  wire        slow_tick,
  // oscillator status
  input  wire        pri_timer_done,
  input  wire        fast_stable,
  // configuration
  input  wire [3:0]  primary_osc_config,
  input  wire        two_speed_startup_cfg,
  // core side
  input  wire        sleep_req,
  output reg         core_clk_tick,
  output reg         wdt_clk_tick,
  output reg         multiplier_on,
  output reg         idle_mode,
  output reg         sleep_mode,
  output reg         switching,
  output reg  [1:0]  active_source
);

  // ***************************************************************
  // bus slave
  // ***************************************************************
  reg        wr_pend_r;
  reg [7:0]  wr_addr_r;
  reg [31:0] hrdata_r;
  wire       addr_ok;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  assign addr_ok   = hsel & htrans[1] & hready;

  // ***************************************************************
  // control state
  // ***************************************************************
  reg        idle_on_sleep_r;
  reg [2:0]  internal_freq_field_r;
  reg [1:0]  source_select_field_r;
  reg        low_freq_source_select_r;
  reg        multiplier_enable_r;
  reg [4:0]  tune_r;
  reg        secondary_osc_enable_r;
  reg [7:0]  sec_timer_other_r;
  reg        pstart_r;
  reg        start_done_r;

  wire wr_ctrl  = wr_pend_r && wr_addr_r == `CLKSW_ADDR_OSC_CTRL;
  wire wr_tune  = wr_pend_r && wr_addr_r == `CLKSW_ADDR_TUNING;
  wire wr_timer = wr_pend_r && wr_addr_r == `CLKSW_ADDR_SEC_TIMER;
  wire [1:0] sel_wr = hwdata[`CLKSW_SEL_HI:`CLKSW_SEL_LO];
  wire sec_en_now = wr_timer ? hwdata[`CLKSW_SECEN_BIT]
                             : secondary_osc_enable_r;
  wire int_primary = primary_osc_config == `CLKSW_PCFG_INT_A ||
                     primary_osc_config == `CLKSW_PCFG_INT_B;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r                <= 1'b0;
      wr_addr_r                <= 8'h00;
      idle_on_sleep_r          <= 1'b0;
      internal_freq_field_r    <= `CLKSW_FREQ_RST;
      source_select_field_r    <= `CLKSW_SEL_PRI;
      low_freq_source_select_r <= 1'b0;
      multiplier_enable_r      <= 1'b0;
      tune_r                   <= 5'h00;
      secondary_osc_enable_r   <= 1'b0;
      sec_timer_other_r        <= 8'h00;
    end
    else
    begin
      wr_pend_r <= addr_ok & hwrite;
      if (addr_ok)
        wr_addr_r <= haddr;
      if (wr_ctrl)
      begin
        idle_on_sleep_r       <= hwdata[`CLKSW_IDLE_BIT];
        internal_freq_field_r <= hwdata[`CLKSW_FREQ_HI:`CLKSW_FREQ_LO];
        // status bits 3:2 are not stored from writes
        if (sel_wr != `CLKSW_SEL_SEC || sec_en_now)
          source_select_field_r <= sel_wr;
      end
      if (wr_tune)
      begin
        low_freq_source_select_r <= hwdata[`CLKSW_LFSRC_BIT];
        multiplier_enable_r      <= hwdata[`CLKSW_MULEN_BIT];
        tune_r                   <= hwdata[`CLKSW_TUNE_HI:0];
      end
      if (wr_timer)
      begin
        secondary_osc_enable_r <= hwdata[`CLKSW_SECEN_BIT];
        sec_timer_other_r      <= hwdata[7:0];
      end
    end
  end

  // multiplier enable reads 0 where unavailable
  wire mul_avail = int_primary &&
                   (internal_freq_field_r == `CLKSW_FREQ_8M ||
                    internal_freq_field_r == `CLKSW_FREQ_4M);
  wire mul_rd = multiplier_enable_r & mul_avail;

  // ***************************************************************
  // internal block frequency
  // ***************************************************************
  wire [7:0] div_tick;
  reg        int_tick;

  clksw_postscaler u_post
  (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .fast_tick(fast_tick),
    .div_tick (div_tick)
  );

  // combinational so a frequency change applies at once
  always @*
  begin
    case (internal_freq_field_r)
      3'h7:    int_tick = fast_tick;
      3'h6:    int_tick = div_tick[0];
      3'h5:    int_tick = div_tick[1];
      3'h4:    int_tick = div_tick[2];
      3'h3:    int_tick = div_tick[3];
      3'h2:    int_tick = div_tick[4];
      3'h1:    int_tick = div_tick[5];
      default: int_tick = low_freq_source_select_r ? div_tick[7]
                                                    : slow_tick;
    endcase
  end

  // ***************************************************************
  // glitch-free switch
  // ***************************************************************
  localparam ST_RUN  = 2'h0;
  localparam ST_OLD  = 2'h1;
  localparam ST_NEW  = 2'h2;

  reg  [1:0] state_r;
  reg  [1:0] state_nxt;
  reg  [1:0] cur_src_r;
  reg        src_tick;
  reg        tgt_tick;
  wire [2:0] old_cnt;
  wire [2:0] new_cnt;
  wire       want_switch = source_select_field_r[1] != cur_src_r[1] ||
                           (!source_select_field_r[1] &&
                            source_select_field_r != cur_src_r);

  function sel_tick;
    input [1:0] s;
    input       p;
    input       q;
    input       r;
    begin
      if (s[1])
        sel_tick = r;
      else if (s[0])
        sel_tick = q;
      else
        sel_tick = p;
    end
  endfunction

  always @*
  begin
    src_tick = sel_tick(cur_src_r, pri_tick, sec_tick, int_tick);
    tgt_tick = sel_tick(source_select_field_r, pri_tick, sec_tick,
                        int_tick);
  end

  clksw_edge_count u_old
  (
    .hclk   (hclk),
    .hresetn(hresetn),
    .clear  (state_r == ST_RUN),
    .tick   (state_r == ST_OLD && src_tick),
    .count  (old_cnt)
  );

  clksw_edge_count u_new
  (
    .hclk   (hclk),
    .hresetn(hresetn),
    .clear  (state_r != ST_NEW),
    .tick   (tgt_tick),
    .count  (new_cnt)
  );

  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN:
        if (want_switch)
          state_nxt = ST_OLD;
      ST_OLD:
        if (old_cnt == {1'b0, `CLKSW_OLD_CYCLES})
          state_nxt = ST_NEW;
      ST_NEW:
        if (new_cnt == {1'b0, `CLKSW_NEW_CYCLES})
          state_nxt = ST_RUN;
      default:
        state_nxt = ST_RUN;
    endcase
  end

  // slow RC tick registered straight onto the watchdog tick
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r       <= ST_RUN;
      cur_src_r     <= `CLKSW_SEL_PRI;
      core_clk_tick <= 1'b0;
      wdt_clk_tick  <= 1'b0;
      multiplier_on <= 1'b0;
      idle_mode     <= 1'b0;
      sleep_mode    <= 1'b0;
      start_done_r  <= 1'b0;
      pstart_r      <= 1'b0;
      hrdata_r      <= 32'h00000000;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r == ST_NEW && state_nxt == ST_RUN)
        cur_src_r <= source_select_field_r;
      // no ticks leave while switching: no glitch
      core_clk_tick <= (state_r == ST_RUN) && !want_switch && src_tick;
      wdt_clk_tick  <= slow_tick;
      multiplier_on <= mul_rd;
      if (sleep_req)
      begin
        idle_mode  <= idle_on_sleep_r;
        sleep_mode <= !idle_on_sleep_r;
      end
      // capture the strap after release
      if (!start_done_r)
      begin
        start_done_r <= 1'b1;
        pstart_r     <= !two_speed_startup_cfg;
      end
      else
        pstart_r <= pri_timer_done;
      hrdata_r <= 32'h00000000;
      if (addr_ok && !hwrite)
        hrdata_r <= {24'h000000, rd_mux(haddr)};
    end
  end

  // ***************************************************************
  // status and read mux
  // ***************************************************************
  wire running = state_r == ST_RUN;
  wire st_pri  = pstart_r && running && cur_src_r == `CLKSW_SEL_PRI;
  wire st_int  = fast_stable && running && cur_src_r[1] &&
                 !(internal_freq_field_r == `CLKSW_FREQ_31K &&
                   !low_freq_source_select_r);
  wire st_sec  = running && cur_src_r == `CLKSW_SEL_SEC;

  always @*
  begin
    switching     = !running;
    active_source = cur_src_r;
  end

  function [7:0] rd_mux;
    input [7:0] a;
    begin
      case (a)
        `CLKSW_ADDR_OSC_CTRL:
          rd_mux = {idle_on_sleep_r, internal_freq_field_r, st_pri,
                    st_int, source_select_field_r};
        `CLKSW_ADDR_TUNING:
          rd_mux = {low_freq_source_select_r, mul_rd, 1'b0, tune_r};
        `CLKSW_ADDR_SEC_TIMER:
          rd_mux = {sec_timer_other_r[7], st_sec, sec_timer_other_r[5:4],
                    secondary_osc_enable_r, sec_timer_other_r[2:0]};
        `CLKSW_ADDR_STATUS:
          rd_mux = {3'h0, switching, primary_osc_config};
        default:
          rd_mux = 8'h00;
      endcase
    end
  endfunction

endmodule // clksw_top

`default_nettype wire

// file: testbench/clksw_assertions.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// port checker for the clock source switch
// ****************************************
module clksw_checker
(
  // bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // sources and configuration
  input wire logic        slow_tick,
  input wire logic [3:0]  primary_osc_config,
  // core side
  input wire logic        sleep_req,
  input wire logic        core_clk_tick,
  input wire logic        wdt_clk_tick,
  input wire logic        multiplier_on,
  input wire logic        idle_mode,
  input wire logic        sleep_mode,
  input wire logic        switching
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ready_high_a: assert property (hreadyout)
    else $error("wait state inserted");
  resp_okay_a: assert property (!hresp)
    else $error("error response");
  read_idle_a: assert property (!(hsel && htrans[1] && !hwrite) |=>
    hrdata == 32'h0) else $error("read data outside read");
  upper_zero_a: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  wdt_follow_a: assert property (hresetn |=>
    wdt_clk_tick == $past(slow_tick)) else $error("watchdog tick lost");
  switch_pause_a: assert property (switching && $past(switching) |->
    !core_clk_tick) else $error("core tick during switch");
  mult_gate_a: assert property (multiplier_on |->
    $past(primary_osc_config[3:1]) == 3'h4)
    else $error("multiplier outside internal mode");
  sleep_kind_a: assert property (sleep_req |=> idle_mode ^ sleep_mode)
    else $error("sleep request without mode");

  cover property ($rose(switching));
  cover property (sleep_req);
  cover property (multiplier_on);
endmodule // clksw_checker

bind clksw_top clksw_checker chk_u (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .slow_tick(slow_tick),
  .primary_osc_config(primary_osc_config), .sleep_req(sleep_req),
  .core_clk_tick(core_clk_tick), .wdt_clk_tick(wdt_clk_tick),
  .multiplier_on(multiplier_on), .idle_mode(idle_mode),
  .sleep_mode(sleep_mode), .switching(switching));

`default_nettype wire

// file: testbench/clksw_osc_model.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// oscillator sources, all free running
// ****************************************
module clksw_osc_model
#(
  parameter int PRI_DIV  = 3,
  parameter int SEC_DIV  = 7,
  parameter int FAST_DIV = 2,
  parameter int SLOW_DIV = 5,
  parameter int WAKE     = 20
)
(
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // source ticks
  output wire logic pri_tick,
  output wire logic sec_tick,
  output wire logic fast_tick,
  output wire logic slow_tick,
  // status levels
  output wire logic pri_timer_done,
  output wire logic fast_stable
);
  logic [15:0] ph_r;

  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      ph_r <= 16'h0000;
    else
      ph_r <= ph_r + 16'h0001;

  // secondary runs from reset so it is stable before any select
  assign sec_tick       = (ph_r % SEC_DIV) == 0;
  assign pri_tick       = (ph_r % PRI_DIV) == 0;
  assign fast_tick      = (ph_r % FAST_DIV) == 0;
  assign slow_tick      = (ph_r % SLOW_DIV) == 0;
  // run is short, so the phase counter never wraps back under WAKE
  assign pri_timer_done = ph_r >= WAKE;
  assign fast_stable    = ph_r >= WAKE / 2;
endmodule // clksw_osc_model

`default_nettype wire

// file: testbench/tb_clock_source_switch.sv
`timescale 1ns/10ps
`default_nettype none

module tb_clock_source_switch;
  logic        hclk, hresetn, hsel, hwrite, sleep_req, rd_ph;
  logic [7:0]  haddr;
  logic [1:0]  htrans, active_source;
  logic [31:0] hwdata, hrdata, rnd;
  logic        hreadyout, hresp, pri_tick, sec_tick, fast_tick, slow_tick;
  logic        pri_timer_done, fast_stable, core_clk_tick, wdt_clk_tick;
  logic        multiplier_on, idle_mode, sleep_mode, switching;
  logic [15:0] exp_q[$];
  logic [15:0] ent;
  logic [3:0]  pcfg;
  int          failures, checks, i;

  clksw_osc_model osc_u (.hclk(hclk), .hresetn(hresetn),
    .pri_tick(pri_tick), .sec_tick(sec_tick), .fast_tick(fast_tick),
    .slow_tick(slow_tick), .pri_timer_done(pri_timer_done),
    .fast_stable(fast_stable));

  clksw_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pri_tick(pri_tick),
    .sec_tick(sec_tick), .fast_tick(fast_tick), .slow_tick(slow_tick),
    .pri_timer_done(pri_timer_done), .fast_stable(fast_stable),
    .primary_osc_config(pcfg), .two_speed_startup_cfg(1'b0),
    .sleep_req(sleep_req), .core_clk_tick(core_clk_tick),
    .wdt_clk_tick(wdt_clk_tick), .multiplier_on(multiplier_on),
    .idle_mode(idle_mode), .sleep_mode(sleep_mode),
    .switching(switching), .active_source(active_source));

  // ****************************************
  // shared tasks
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic chk(input string n, input logic [31:0] s, e);
    checks++;
    if (s !== e)
    begin
      failures++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
  endtask

  // expected value and mask are noted before the read is issued
  task automatic rd(input logic [7:0] a, e, m);
    exp_q.push_back({e, m});
    xfer(1'b0, a, 8'h00);
  endtask

  task automatic settle;
    @(posedge hclk);
    while (switching) @(posedge hclk);
  endtask

  // counts core ticks over n edges; an unknown pin spoils the count
  task automatic ticks(input int n, input logic [31:0] e);
    logic [31:0] c;
    c = 32'h0;
    repeat (n)
    begin
      @(posedge hclk);
      c = c + core_clk_tick;
    end
    chk("core ticks", c, e);
  endtask

  task automatic results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ****************************************
  // read data monitor
  // ****************************************
  always @(posedge hclk)
  begin
    if (rd_ph)
    begin
      ent = exp_q.pop_front();
      chk("hrdata", hrdata & {24'hFFFFFF, ent[7:0]}, {24'h0, ent[15:8]});
    end
    rd_ph <= hsel & htrans[1] & !hwrite;
  end

  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  initial
  begin
    #(100 * 20000);
    failures++;
    results;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    {hresetn, hsel, hwrite, sleep_req, rd_ph} = 5'h00;
    {haddr, htrans, hwdata} = 42'h0;
    failures = 0;
    checks = 0;
    pcfg = 4'h8;
    rnd = 32'h68C4;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(8'h00, 8'h08, 8'h08);
    rd(8'h00, 8'h00, 8'h08);
    repeat (30) @(posedge hclk);
    rd(8'h00, 8'h48, 8'hFB);
    $display("reset values done");
    for (i = 0; i < 8; i++)
    begin
      xfer(1'b1, 8'h00, {1'b0, i[2:0], 4'hE});
      rd(8'h00, {1'b0, i[2:0], i[2:0] == 3'h0, 3'h2}, 8'hFB);
      settle;
    end
    chk("source", active_source, 2'h2);
    rd(8'h00, 8'h76, 8'hF7);
    ticks(16, 32'h8);
    for (i = 0; i < 3; i++)
    begin
      rnd = lfsr(rnd);
      xfer(1'b1, 8'h04, {3'h2, rnd[4:0]});
      rd(8'h04, {3'h0, rnd[4:0]}, 8'h1F);
    end
    repeat (2) @(posedge hclk);
    chk("mult on", multiplier_on, 1'b1);
    pcfg <= 4'h2;
    repeat (2) @(posedge hclk);
    chk("mult cfg", multiplier_on, 1'b0);
    pcfg <= 4'h9;
    repeat (2) @(posedge hclk);
    chk("mult cfg", multiplier_on, 1'b1);
    xfer(1'b1, 8'h00, 8'h52);
    repeat (2) @(posedge hclk);
    chk("no pause", switching, 1'b0);
    ticks(64, 32'h8);
    repeat (2) @(posedge hclk);
    chk("mult off", multiplier_on, 1'b0);
    xfer(1'b1, 8'h00, 8'h02);
    xfer(1'b1, 8'h04, 8'h00);
    rd(8'h00, 8'h00, 8'h04);
    xfer(1'b1, 8'h04, 8'h80);
    repeat (4) @(posedge hclk);
    rd(8'h00, 8'h04, 8'h04);
    ticks(1024, 32'h2);
    $display("internal block done");
    xfer(1'b1, 8'h08, 8'h00);
    xfer(1'b1, 8'h00, 8'h01);
    rd(8'h00, 8'h02, 8'h03);
    xfer(1'b1, 8'h08, 8'h08);
    xfer(1'b1, 8'h00, 8'h01);
    repeat (2) @(posedge hclk);
    chk("switch start", switching, 1'b1);
    settle;
    chk("source", active_source, 2'h1);
    ticks(70, 32'hA);
    rd(8'h08, 8'h48, 8'h48);
    rd(8'h00, 8'h01, 8'h0F);
    xfer(1'b1, 8'h10, 8'hFF);
    rd(8'h10, 8'h00, 8'hFF);
    $display("secondary done");
    xfer(1'b1, 8'h00, 8'h81);
    sleep_req <= 1'b1;
    @(posedge hclk);
    sleep_req <= 1'b0;
    @(posedge hclk);
    chk("idle", idle_mode, 1'b1);
    xfer(1'b1, 8'h00, 8'h01);
    sleep_req <= 1'b1;
    @(posedge hclk);
    sleep_req <= 1'b0;
    @(posedge hclk);
    chk("sleep", sleep_mode, 1'b1);
    $display("sleep done");
    // mid-run reset must drop the secondary select and the 31 kHz code
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("source", active_source, 2'h0);
    rd(8'h00, 8'h40, 8'hF3);
    $display("reset rerun done");
    results;
  end
endmodule // tb_clock_source_switch

`default_nettype wire
